// ---- rvc_pkg.sv ----
package rvc_pkg;

    // ========================================================================
    // Register map and field layout
    // ========================================================================
    localparam logic [7:0] REG_CTRL_ADDR = 8'hc9;
    localparam logic [7:0] REG_CTRL_RST  = 8'h00;
    localparam int         BIT_DISABLE   = 7;
    localparam int         BIT_VBUS_STAT = 6;
    localparam int         BIT_POLARITY  = 5;
    localparam int         BIT_LOW_POWER = 4;
    localparam logic [7:0] WRITE_MASK    = 8'hb0;

    // ========================================================================
    // Types
    // ========================================================================
    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rvc_sfr_req_s;

    typedef struct packed {
        logic disable_reg;
        logic low_power;
        logic polarity;
    } rvc_ctrl_s;

endpackage

// ---- rvc_match.sv ----
`timescale 1ns/1ps
module rvc_match
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Sense and selection
    input  wire logic vbus_sense,
    input  wire logic polarity,
    input  wire logic int_enable,
    input  wire logic usb_reset_source,
    // Requests
    output logic      vbus_irq_q,
    output logic      vbus_reset_q
);

    // ========================================================================
    // Level comparison
    // ========================================================================
    logic match;
    logic irq_d;
    logic reset_d;

    always_comb
    begin
        match   = (vbus_sense == polarity);
        irq_d   = int_enable & match;
        reset_d = usb_reset_source & match;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            vbus_irq_q   <= 1'b0;
            vbus_reset_q <= 1'b0;
        end
        else
        begin
            vbus_irq_q   <= irq_d;
            vbus_reset_q <= reset_d;
        end
    end

endmodule // rvc_match

// ---- rvc_regulator_ctrl.sv ----
`timescale 1ns/1ps
module rvc_regulator_ctrl
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    // Special function register access
    input  wire rvc_pkg::rvc_sfr_req_s sfr_req,
    output logic [7:0]                 sfr_rdata_q,
    output logic                       sfr_rvalid_q,
    // Bus-power sense and system links
    input  wire logic                  vbus_sense,
    input  wire logic                  vbus_int_enable,
    input  wire logic                  usb_reset_source,
    // Regulator and request outputs
    output logic                       regulator_disable_q,
    output logic                       regulator_low_power_select_q,
    output logic                       vbus_irq_q,
    output logic                       vbus_reset_q
);

    // ========================================================================
    // Control register
    // ========================================================================
    rvc_pkg::rvc_ctrl_s ctrl_q;
    rvc_pkg::rvc_ctrl_s ctrl_d;
    logic               sel;

    always_comb
    begin
        sel    = (sfr_req.addr == rvc_pkg::REG_CTRL_ADDR);
        ctrl_d = ctrl_q;
        if (sfr_req.wr_en && sel)
        begin
            ctrl_d.disable_reg = sfr_req.wdata[rvc_pkg::BIT_DISABLE];
            ctrl_d.polarity    = sfr_req.wdata[rvc_pkg::BIT_POLARITY];
            ctrl_d.low_power   = sfr_req.wdata[rvc_pkg::BIT_LOW_POWER];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ctrl_q <= '0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
        end
    end

    // ========================================================================
    // Read path and regulator outputs
    // ========================================================================
    logic [7:0] rdata_d;
    logic       rvalid_d;

    always_comb
    begin
        rdata_d  = 8'h00;
        rvalid_d = sfr_req.rd_en;
        if (sfr_req.rd_en && sel)
        begin
            rdata_d[rvc_pkg::BIT_DISABLE]   = ctrl_q.disable_reg;
            rdata_d[rvc_pkg::BIT_VBUS_STAT] = vbus_sense;
            rdata_d[rvc_pkg::BIT_POLARITY]  = ctrl_q.polarity;
            rdata_d[rvc_pkg::BIT_LOW_POWER] = ctrl_q.low_power;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            sfr_rdata_q                  <= rvc_pkg::REG_CTRL_RST;
            sfr_rvalid_q                 <= 1'b0;
            regulator_disable_q          <= 1'b0;
            regulator_low_power_select_q <= 1'b0;
        end
        else
        begin
            sfr_rdata_q                  <= rdata_d;
            sfr_rvalid_q                 <= rvalid_d;
            regulator_disable_q          <= ctrl_d.disable_reg;
            regulator_low_power_select_q <= ctrl_d.low_power;
        end
    end

    // ========================================================================
    // Level-sensitive interrupt and reset request
    // ========================================================================
    rvc_match u_match
    (
        .ref_clk          (ref_clk),
        .rst              (rst),
        .vbus_sense       (vbus_sense),
        .polarity         (ctrl_q.polarity),
        .int_enable       (vbus_int_enable),
        .usb_reset_source (usb_reset_source),
        .vbus_irq_q       (vbus_irq_q),
        .vbus_reset_q     (vbus_reset_q)
    );

endmodule // rvc_regulator_ctrl

// ---- rvc_vbus_model.sv ----
`timescale 1ns/1ps
module rvc_vbus_model
(
    // Clock and requested cable state
    input  wire logic ref_clk,
    input  wire logic attach,
    // Digitised sense level
    output logic      vbus_sense
);
    always_ff @(posedge ref_clk)
        vbus_sense <= attach;
endmodule // rvc_vbus_model

// ---- rvc_monitor.sv ----
`timescale 1ns/1ps
module rvc_monitor
(
    // Watched ports
    input wire logic ref_clk, rst, sfr_rvalid_q, vbus_sense,
    input wire logic vbus_int_enable, usb_reset_source, vbus_irq_q,
    input wire logic regulator_disable_q, regulator_low_power_select_q,
    input wire logic vbus_reset_q,
    input wire logic [7:0] sfr_rdata_q,
    input wire rvc_pkg::rvc_sfr_req_s sfr_req
);
    // ====
    // Polarity shadow
    logic pol_q;
    wire w = sfr_req.wr_en && sfr_req.addr == rvc_pkg::REG_CTRL_ADDR;
    always_ff @(posedge ref_clk)
        pol_q <= rst ? 1'b0 : (w ? sfr_req.wdata[5] : pol_q);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ====
    // Checks
    a_irq_match: assert property (!$past(rst) |-> vbus_irq_q ==
        $past(vbus_int_enable && vbus_sense == pol_q)) else $error("irq");
    a_reset_match: assert property (!$past(rst) |-> vbus_reset_q ==
        $past(usb_reset_source && vbus_sense == pol_q)) else $error("rst");
    a_dis_write: assert property (w |=>
        regulator_disable_q == $past(sfr_req.wdata[7])) else $error("dis");
    a_lp_write: assert property (w |=>
        regulator_low_power_select_q == $past(sfr_req.wdata[4]))
        else $error("lp");
    a_dis_hold: assert property (!w |=>
        $stable(regulator_disable_q)) else $error("hold");
    a_stat_read: assert property (sfr_req.rd_en && !w
        && sfr_req.addr == rvc_pkg::REG_CTRL_ADDR |=> sfr_rvalid_q
        && sfr_rdata_q[6] == $past(vbus_sense)) else $error("stat");
    a_rsvd_zero: assert property (sfr_rvalid_q |->
        sfr_rdata_q[3:0] == 4'h0) else $error("rsvd");
    a_reset_on: assert property ($fell(rst) |-> !regulator_disable_q
        && !regulator_low_power_select_q) else $error("on");
endmodule // rvc_monitor
bind rvc_regulator_ctrl rvc_monitor mon (.*);

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 0, rst = 1, att = 0, vbus_int_enable = 0;
    logic usb_reset_source = 0, vbus_sense, sfr_rvalid_q, vbus_irq_q;
    logic regulator_disable_q, regulator_low_power_select_q, vbus_reset_q;
    logic [7:0] sfr_rdata_q;
    rvc_pkg::rvc_sfr_req_s sfr_req = '0;
    int error_cnt = 0, checks = 0;
    always #2.5 ref_clk = ~ref_clk;
    rvc_vbus_model m (.ref_clk, .attach(att), .vbus_sense);
    rvc_regulator_ctrl dut (.*);
    // ====
    // Access tasks
    task chk(input logic [7:0] g, e);
        checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task acc(input logic r, input logic [7:0] a, d);
        @(posedge ref_clk) sfr_req <= '{!r, r, a, d};
        @(posedge ref_clk) sfr_req <= '0;
        @(negedge ref_clk);
        if (r) chk({sfr_rvalid_q, 7'h0} | sfr_rdata_q, 8'h80 | d);
    endtask
    task lvl(input logic [7:0] e);
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk) chk({vbus_irq_q, vbus_reset_q}, e);
    endtask
    task final_report;
        if (error_cnt == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ====
    // Sequence
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst <= 0;
        acc(1, 8'hc9, 8'h00);
        acc(0, 8'hc9, 8'hff);
        chk({regulator_disable_q, regulator_low_power_select_q}, 3);
        acc(1, 8'hc9, 8'hb0);
        @(posedge ref_clk);
        att <= 1;
        vbus_int_enable <= 1;
        usb_reset_source <= 1;
        lvl(3);
        acc(1, 8'hc9, 8'hf0);
        @(posedge ref_clk);
        att <= 0;
        lvl(0);
        acc(0, 8'hc9, 8'h40);
        lvl(3);
        chk({regulator_disable_q, regulator_low_power_select_q}, 0);
        acc(0, 8'hc8, 8'hff);
        acc(1, 8'hc9, 8'h00);
        acc(1, 8'hc8, 8'h00);
        @(posedge ref_clk);
        vbus_int_enable <= 0;
        lvl(1);
        final_report();
    end
endmodule // tb_top
